// ---- lcs_cell.sv ----
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
// ==========================================================
// Function
// - local preset/clear input is active high, no inversion inside the cell
// - each element has own preset-or-clear state and own local enable
// - global net forces elements to configured state at reset, reload, assertion
// - global net forces the same state as the local preset/clear
// - element data comes from first, second, third generator or direct input
// - each registered output muxes element output or a control input
// - any external control input may drive any internal control signal
// - logic mode: clock gate, preset/clear, direct input, third generator inputs
// - memory mode: clock gate, write enable, data zero, data one or address msb
// - first two tables are ram: level, edge single-port, edge dual-port
// - memory organises as 16x2, 32x1 or 16x1
// - 32x1 mode gives both tables one address, fifth bit picks table
// - elements work as registers while generators do unrelated logic
// - storage is a d flip-flop with clock enable and asynchronous preset or clear
// - one bit per element sets start state, global and local response
module lcs_cell
	import lcs_pkg::*;
(
	// clock, reset, global freeze
	input  wire logic              CORE_CLK,
	input  wire logic              RST,
	input  wire logic              CLK_EN,
	// register port
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	output logic      [DATA_W-1:0] REG_RDATA,
	// fabric inputs
	input  wire logic [3:0]        EXTERNAL_CONTROL_INPUTS,
	input  wire logic [3:0]        F_IN,
	input  wire logic [3:0]        G_IN,
	input  wire logic              GLOBAL_PRESET_CLEAR_NET,
	// fabric outputs
	output logic                   F_OUT,
	output logic                   G_OUT,
	output logic                   H_OUT,
	output logic                   REGISTERED_OUT_FIRST,
	output logic                   REGISTERED_OUT_SECOND
);

	// ==========================================================
	// configuration registers
	logic [ST_WIDTH-1:0] store_r;
	logic [MP_WIDTH-1:0] map_r;
	logic [7:0]          luth_r;
	logic                reload_r;
	logic [DATA_W-1:0]   rdata_r;
	logic [DATA_W-1:0]   rdata_nxt;

	// ==========================================================
	// decoded configuration
	logic                mem_en;
	lcs_org_t            org;
	lcs_wmode_t          wmode;
	lcs_dsel_t           dsel_first;
	lcs_dsel_t           dsel_second;

	// ==========================================================
	// internal control signals
	logic                cell_clock_gate;
	logic                ctl_one;
	logic                ctl_two;
	logic                ctl_three;
	logic                local_async_preset_clear;
	logic                third_gen_input_zero;
	logic                third_gen_input_one;
	logic                third_gen_input_two;
	logic                write_enable;
	logic                ram_data_zero;
	logic                ram_data_one_or_addr_msb;
	logic                direct_in;

	// ==========================================================
	// generator and storage nets
	logic                f_gen;
	logic                g_gen;
	logic                h_gen;
	logic [2:0]          h_addr;
	logic [15:0]         f_tab;
	logic [15:0]         g_tab;
	logic                d_first;
	logic                d_second;
	logic                q_first;
	logic                q_second;
	logic                wr_hit_store;
	logic                wr_hit_map;

	// ==========================================================
	// register writes
	assign wr_hit_store = REG_WR & (REG_ADDR == OFF_STORE);
	assign wr_hit_map   = REG_WR & (REG_ADDR == OFF_MAP);

	// storage and mapping setup
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			store_r <= STORE_RST;
			map_r   <= MAP_RST;
		end else if (CLK_EN) begin
			if (wr_hit_store) begin
				store_r <= REG_WDATA[ST_WIDTH-1:0];
			end
			if (wr_hit_map) begin
				map_r <= REG_WDATA[MP_WIDTH-1:0];
			end
		end
	end

	// third generator table, not usable as ram
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			luth_r <= LUTH_RST;
		end else if (CLK_EN && REG_WR && REG_ADDR == OFF_LUT_H) begin
			luth_r <= REG_WDATA[7:0];
		end
	end

	// a setup write counts as reconfiguration: elements restart from their state
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			reload_r <= 1'b0;
		end else if (CLK_EN) begin
			reload_r <= wr_hit_store | wr_hit_map;
		end
	end

	// ==========================================================
	// register reads: data stand only in the cycle after the strobe
	always_comb begin
		rdata_nxt = '0;
		if (REG_RD) begin
			unique case (REG_ADDR)
				OFF_STORE:  rdata_nxt[ST_WIDTH-1:0] = store_r;
				OFF_MAP:    rdata_nxt[MP_WIDTH-1:0] = map_r;
				OFF_LUT_F:  rdata_nxt[15:0] = f_tab;
				OFF_LUT_G:  rdata_nxt[15:0] = g_tab;
				OFF_LUT_H:  rdata_nxt[7:0] = luth_r;
				OFF_STATUS: rdata_nxt[4:0] = {H_OUT, G_OUT, F_OUT, q_second, q_first};
				default:    rdata_nxt = '0; // unmapped reads as zero
			endcase
		end
	end

	// read data register
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			rdata_r <= '0;
		end else if (CLK_EN) begin
			rdata_r <= rdata_nxt;
		end
	end

	assign REG_RDATA = rdata_r;

	// ==========================================================
	// configuration decode
	assign mem_en      = map_r[MP_MEM];
	assign org         = lcs_org_t'(map_r[MP_ORG +: 2]);
	assign wmode       = lcs_wmode_t'(map_r[MP_WMODE +: 2]);
	assign dsel_first  = lcs_dsel_t'(store_r[ST_DSEL1 +: 2]);
	assign dsel_second = lcs_dsel_t'(store_r[ST_DSEL2 +: 2]);

	// ==========================================================
	// control mapping: any external input onto any internal signal
	assign cell_clock_gate = pick4(EXTERNAL_CONTROL_INPUTS, map_r[MP_EC +: 2]);
	assign ctl_one         = pick4(EXTERNAL_CONTROL_INPUTS, map_r[MP_SR +: 2]);
	assign ctl_two         = pick4(EXTERNAL_CONTROL_INPUTS, map_r[MP_DIN +: 2]);
	assign ctl_three       = pick4(EXTERNAL_CONTROL_INPUTS, map_r[MP_H1 +: 2]);

	// logic-mode meaning; preset/clear is taken as is, active high
	assign local_async_preset_clear = ~mem_en & ctl_one;
	assign third_gen_input_zero     = ctl_one;
	assign direct_in                = ctl_two;
	assign third_gen_input_two      = ctl_two;
	assign third_gen_input_one      = ctl_three;

	// memory-mode meaning of the same three signals
	assign write_enable             = mem_en & ctl_one;
	assign ram_data_zero            = ctl_two;
	assign ram_data_one_or_addr_msb = ctl_three;

	// ==========================================================
	// first and second generators, optionally ram
	lcs_lut_ram u_lut (
		.clk       (CORE_CLK),
		.rst       (RST),
		.clk_en    (CLK_EN),
		.load_f    (REG_WR && REG_ADDR == OFF_LUT_F),
		.load_g    (REG_WR && REG_ADDR == OFF_LUT_G),
		.load_data (REG_WDATA[15:0]),
		.mem_en    (mem_en),
		.org       (org),
		.wmode     (wmode),
		.cell_ce   (cell_clock_gate),
		.we        (write_enable),
		.d0        (ram_data_zero),
		.d1        (ram_data_one_or_addr_msb),
		.f_addr    (F_IN),
		.g_addr    (G_IN),
		.f_out     (f_gen),
		.g_out     (g_gen),
		.f_tab     (f_tab),
		.g_tab     (g_tab)
	);

	// ==========================================================
	// third generator: generator outputs or the control inputs feed it
	assign h_addr[0] = map_r[MP_HSEL0] ? third_gen_input_zero : f_gen;
	assign h_addr[1] = map_r[MP_HSEL2] ? third_gen_input_two : g_gen;
	assign h_addr[2] = third_gen_input_one;

	// in 32x1 the fifth address bit picks which table answers
	always_comb begin
		if (mem_en && org == ORG_32X1) begin
			h_gen = ram_data_one_or_addr_msb ? g_gen : f_gen;
		end else begin
			h_gen = luth_r[h_addr];
		end
	end

	// generator results leave combinationally, as they do in the fabric
	assign F_OUT = f_gen;
	assign G_OUT = g_gen;
	assign H_OUT = h_gen;

	// ==========================================================
	// element data source selection
	always_comb begin
		unique case (dsel_first)
			SRC_F:   d_first = f_gen;
			SRC_G:   d_first = g_gen;
			SRC_H:   d_first = h_gen;
			SRC_DIN: d_first = direct_in;
		endcase
	end

	// second element selection, independent of the first
	always_comb begin
		unique case (dsel_second)
			SRC_F:   d_second = f_gen;
			SRC_G:   d_second = g_gen;
			SRC_H:   d_second = h_gen;
			SRC_DIN: d_second = direct_in;
		endcase
	end

	// ==========================================================
	// storage elements; they run beside any generator use
	lcs_store_elem u_first (
		.clk      (CORE_CLK),
		.rst      (RST),
		.clk_en   (CLK_EN),
		.ld_cfg   (reload_r),
		.init_set (store_r[ST_INIT1]),
		.sr_en    (store_r[ST_SREN1]),
		.cell_ce  (cell_clock_gate),
		.sr       (local_async_preset_clear),
		.global_preset_clear_net      (GLOBAL_PRESET_CLEAR_NET),
		.d        (d_first),
		.q        (q_first)
	);

	lcs_store_elem u_second (
		.clk      (CORE_CLK),
		.rst      (RST),
		.clk_en   (CLK_EN),
		.ld_cfg   (reload_r),
		.init_set (store_r[ST_INIT2]),
		.sr_en    (store_r[ST_SREN2]),
		.cell_ce  (cell_clock_gate),
		.sr       (local_async_preset_clear),
		.global_preset_clear_net      (GLOBAL_PRESET_CLEAR_NET),
		.d        (d_second),
		.q        (q_second)
	);

	// ==========================================================
	// output bypass: feed-through lets the router repower a control input
	assign REGISTERED_OUT_FIRST = store_r[ST_BYP1] ?
		pick4(EXTERNAL_CONTROL_INPUTS, store_r[ST_BSRC1 +: 2]) : q_first;
	assign REGISTERED_OUT_SECOND = store_r[ST_BYP2] ?
		pick4(EXTERNAL_CONTROL_INPUTS, store_r[ST_BSRC2 +: 2]) : q_second;

endmodule

// ---- lcs_pkg.sv ----
// ==========================================================
// shared constants, field layout and helper functions
package lcs_pkg;

	// ==========================================================
	// register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_STORE  = 8'h00;
	localparam logic [7:0] OFF_MAP    = 8'h04;
	localparam logic [7:0] OFF_LUT_F  = 8'h08;
	localparam logic [7:0] OFF_LUT_G  = 8'h0C;
	localparam logic [7:0] OFF_LUT_H  = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;

	// ==========================================================
	// storage configuration fields
	localparam int ST_INIT1   = 0;
	localparam int ST_INIT2   = 1;
	localparam int ST_SREN1   = 2;
	localparam int ST_SREN2   = 3;
	localparam int ST_DSEL1   = 4;
	localparam int ST_DSEL2   = 6;
	localparam int ST_BYP1    = 8;
	localparam int ST_BYP2    = 9;
	localparam int ST_BSRC1   = 10;
	localparam int ST_BSRC2   = 12;
	localparam int ST_WIDTH   = 14;

	// ==========================================================
	// control mapping and memory mode fields
	localparam int MP_EC      = 0;
	localparam int MP_SR      = 2;
	localparam int MP_DIN     = 4;
	localparam int MP_H1      = 6;
	localparam int MP_MEM     = 8;
	localparam int MP_ORG     = 9;
	localparam int MP_WMODE   = 11;
	localparam int MP_HSEL0   = 13;
	localparam int MP_HSEL2   = 14;
	localparam int MP_WIDTH   = 15;

	// ==========================================================
	// reset values
	localparam logic [ST_WIDTH-1:0] STORE_RST = 14'h000C;
	localparam logic [MP_WIDTH-1:0] MAP_RST   = 15'h00E4;
	localparam logic [15:0]         LUT_RST   = 16'h0000;
	localparam logic [7:0]          LUTH_RST  = 8'h00;

	// ==========================================================
	// enumerations
	typedef enum logic [1:0] {SRC_F = 2'h0, SRC_G = 2'h1, SRC_H = 2'h2, SRC_DIN = 2'h3} lcs_dsel_t;
	typedef enum logic [1:0] {ORG_16X2 = 2'h0, ORG_32X1 = 2'h1, ORG_16X1 = 2'h2} lcs_org_t;
	typedef enum logic [1:0] {WM_LEVEL = 2'h0, WM_EDGE = 2'h1, WM_DUAL = 2'h2} lcs_wmode_t;

	// ==========================================================
	// one of four by index
	function automatic logic pick4(input logic [3:0] v, input logic [1:0] s);
		pick4 = v[s];
	endfunction

	// one bit of a 16-entry table
	function automatic logic lut_rd(input logic [15:0] t, input logic [3:0] a);
		lut_rd = t[a];
	endfunction

endpackage

// ---- lcs_store_elem.sv ----
`timescale 1ns/1ps
// ==========================================================
// one storage element: d flip-flop, clock gate, preset/clear
module lcs_store_elem
	import lcs_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic clk_en,
	// configuration
	input  wire logic ld_cfg,
	input  wire logic init_set,
	input  wire logic sr_en,
	// cell controls
	input  wire logic cell_ce,
	input  wire logic sr,
	input  wire logic global_preset_clear_net,
	input  wire logic d,
	// state
	output logic      q
);
	logic q_r;
	logic force_now;

	// global net and enabled local input both force the configured state
	assign force_now = global_preset_clear_net | (sr & sr_en);

	// clock gate holds the value, forcing ignores the gate
	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= 1'b0;
		end else if (clk_en) begin
			if (ld_cfg | force_now) begin
				q_r <= init_set;
			end else if (cell_ce) begin
				q_r <= d;
			end
		end
	end

	// forced value shows at once, not only after the next edge
	assign q = force_now ? init_set : q_r;

endmodule

// ---- lcs_lut_ram.sv ----
`timescale 1ns/1ps
// ==========================================================
// first and second function tables, usable as small ram
module lcs_lut_ram
	import lcs_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// whole-table loads from the register port
	input  wire logic        load_f,
	input  wire logic        load_g,
	input  wire logic [15:0] load_data,
	// mode
	input  wire logic        mem_en,
	input  wire lcs_org_t    org,
	input  wire lcs_wmode_t  wmode,
	// memory controls
	input  wire logic        cell_ce,
	input  wire logic        we,
	input  wire logic        d0,
	input  wire logic        d1,
	input  wire logic [3:0]  f_addr,
	input  wire logic [3:0]  g_addr,
	// results
	output logic             f_out,
	output logic             g_out,
	output logic [15:0]      f_tab,
	output logic [15:0]      g_tab
);
	logic        do_wr;
	logic        wr_f;
	logic        wr_g;
	logic        dat_g;
	logic [3:0]  wa_g;
	logic [3:0]  ra_g;
	logic        level;

	// write decode per organisation
	always_comb begin
		level = (wmode == WM_LEVEL);
		do_wr = mem_en & we & (level | cell_ce);
		wa_g  = ((wmode == WM_DUAL) || (org == ORG_32X1)) ? f_addr : g_addr;
		ra_g  = (org == ORG_32X1) ? f_addr : g_addr;
		dat_g = ((org == ORG_16X2) && (wmode != WM_DUAL)) ? d1 : d0;
		wr_f  = do_wr & ((org != ORG_32X1) | ~d1);
		wr_g  = do_wr & ((wmode == WM_DUAL) | (org == ORG_16X2) | ((org == ORG_32X1) & d1));
	end

	// table storage: register loads win over cell writes
	always_ff @(posedge clk) begin
		if (rst) begin
			f_tab <= LUT_RST;
			g_tab <= LUT_RST;
		end else if (clk_en) begin
			if (load_f) begin
				f_tab <= load_data;
			end else if (wr_f) begin
				f_tab[f_addr] <= d0;
			end
			if (load_g) begin
				g_tab <= load_data;
			end else if (wr_g) begin
				g_tab[wa_g] <= dat_g;
			end
		end
	end

	// reads stay combinational; level mode is transparent while writing
	assign f_out = (level & wr_f) ? d0 : lut_rd(f_tab, f_addr);
	assign g_out = (level & wr_g && ra_g == wa_g) ? dat_g : lut_rd(g_tab, ra_g);

endmodule

// ---- lcs_cell_sva.sv ----
`timescale 1ns/1ps
// ==========================================================
// cell checker on the top-level pins
module lcs_cell_chk
	import lcs_pkg::*;
(
	// clock and reset
	input wire logic              CORE_CLK,
	input wire logic              RST,
	input wire logic              CLK_EN,
	// register port
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic              REG_WR,
	input wire logic              REG_RD,
	input wire logic [DATA_W-1:0] REG_RDATA,
	// fabric side
	input wire logic [3:0]        EXTERNAL_CONTROL_INPUTS,
	input wire logic [3:0]        F_IN,
	input wire logic [3:0]        G_IN,
	input wire logic              GLOBAL_PRESET_CLEAR_NET,
	input wire logic              F_OUT,
	input wire logic              G_OUT,
	input wire logic              H_OUT,
	input wire logic              REGISTERED_OUT_FIRST,
	input wire logic              REGISTERED_OUT_SECOND
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ==========================================================
	// configuration shadow, snooped from register writes
	logic [ST_WIDTH-1:0] st_r;
	logic [MP_WIDTH-1:0] mp_r;
	logic                ec, we, d0, d1, mem, ew, frc1, frc2;
	// storage setup shadow
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st_r <= STORE_RST;
		end else if (CLK_EN && REG_WR && REG_ADDR == OFF_STORE) begin
			st_r <= REG_WDATA[ST_WIDTH-1:0];
		end
	end
	// mapping shadow
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			mp_r <= MAP_RST;
		end else if (CLK_EN && REG_WR && REG_ADDR == OFF_MAP) begin
			mp_r <= REG_WDATA[MP_WIDTH-1:0];
		end
	end
	// routed controls; forced means the pin does not show the bare flop
	assign ec   = EXTERNAL_CONTROL_INPUTS[mp_r[1:0]];
	assign we   = EXTERNAL_CONTROL_INPUTS[mp_r[3:2]];
	assign d0   = EXTERNAL_CONTROL_INPUTS[mp_r[5:4]];
	assign d1   = EXTERNAL_CONTROL_INPUTS[mp_r[7:6]];
	assign mem  = mp_r[MP_MEM];
	assign ew   = mem && mp_r[12:11] != WM_LEVEL && we && ec;
	assign frc1 = GLOBAL_PRESET_CLEAR_NET || st_r[ST_BYP1] || (!mem && st_r[ST_SREN1] && we);
	assign frc2 = GLOBAL_PRESET_CLEAR_NET || st_r[ST_BYP2] || (!mem && st_r[ST_SREN2] && we);
	// no setup write may reload the elements across this edge
	sequence s_idle(x);
		CLK_EN && !REG_WR && !$past(REG_WR) && x;
	endsequence
	// ==========================================================
	// assertions
	AST_GSR_FIRST: assert property (GLOBAL_PRESET_CLEAR_NET && !st_r[ST_BYP1] |->
		REGISTERED_OUT_FIRST == st_r[ST_INIT1]) else $error("global force wrong on first output");
	AST_GSR_SECOND: assert property (GLOBAL_PRESET_CLEAR_NET && !st_r[ST_BYP2] |->
		REGISTERED_OUT_SECOND == st_r[ST_INIT2]) else $error("global force wrong on second output");
	AST_LOCAL_FIRST: assert property (!mem && st_r[ST_SREN1] && we && !st_r[ST_BYP1] |->
		REGISTERED_OUT_FIRST == st_r[ST_INIT1]) else $error("local force wrong on first output");
	AST_BYP_FIRST: assert property (st_r[ST_BYP1] |->
		REGISTERED_OUT_FIRST == EXTERNAL_CONTROL_INPUTS[st_r[11:10]]) else $error("first bypass wrong");
	AST_BYP_SECOND: assert property (st_r[ST_BYP2] |->
		REGISTERED_OUT_SECOND == EXTERNAL_CONTROL_INPUTS[st_r[13:12]]) else $error("second bypass wrong");
	AST_HOLD_FIRST: assert property (s_idle(!ec && !frc1) ##1 !frc1 |->
		$stable(REGISTERED_OUT_FIRST)) else $error("first element moved with gate low");
	AST_HOLD_SECOND: assert property (s_idle(!ec && !frc2) ##1 !frc2 |->
		$stable(REGISTERED_OUT_SECOND)) else $error("second element moved with gate low");
	AST_LOAD_FIRST: assert property (s_idle(ec && !frc1 && !mem && st_r[5:4] == SRC_DIN) ##1 !frc1 |->
		REGISTERED_OUT_FIRST == $past(d0)) else $error("first element missed direct data");
	AST_RAM_WR: assert property (s_idle(ew && mp_r[10:9] != ORG_32X1) ##1 $stable(F_IN) |->
		F_OUT == $past(d0)) else $error("edge write not seen on first table");
	AST_RAM_KEEP: assert property (s_idle(mem && mp_r[12:11] != WM_LEVEL && !(we && ec)) ##1 $stable(F_IN) |->
		$stable(F_OUT)) else $error("table changed without write");
	AST_RAM_32: assert property (s_idle(ew && mp_r[10:9] == ORG_32X1) ##1 $stable(F_IN) && $stable(d1) |->
		H_OUT == $past(d0)) else $error("deep mode write not seen");
endmodule

bind lcs_cell lcs_cell_chk u_chk (
	.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
	.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXTERNAL_CONTROL_INPUTS(EXTERNAL_CONTROL_INPUTS),
	.F_IN(F_IN), .G_IN(G_IN), .GLOBAL_PRESET_CLEAR_NET(GLOBAL_PRESET_CLEAR_NET), .F_OUT(F_OUT),
	.G_OUT(G_OUT), .H_OUT(H_OUT), .REGISTERED_OUT_FIRST(REGISTERED_OUT_FIRST),
	.REGISTERED_OUT_SECOND(REGISTERED_OUT_SECOND)
);

// ---- lcs_fabric.sv ----
`timescale 1ns/1ps
// ==========================================================
// surrounding fabric: applies the next input set just after an edge
module lcs_fabric (
	// clock
	input  wire logic       clk,
	// requested levels
	input  wire logic [3:0] nxt_ctl,
	input  wire logic [3:0] nxt_f,
	input  wire logic [3:0] nxt_g,
	input  wire logic       nxt_gsr,
	// cell inputs
	output logic      [3:0] ctl,
	output logic      [3:0] f_in,
	output logic      [3:0] g_in,
	output logic            global_preset_clear_net
);
	// quiet levels at time zero
	initial begin
		ctl = 4'h0;
		f_in = 4'h0;
		g_in = 4'h0;
		global_preset_clear_net = 1'h0;
	end
	// global net comes from an internal node here, not a pin
	always @(posedge clk) begin
		global_preset_clear_net <= nxt_gsr;
	end
	// controls and addresses never move at the sampling instant
	always @(posedge clk) begin
		ctl <= nxt_ctl;
		f_in <= nxt_f;
		g_in <= nxt_g;
	end
endmodule

// ---- lcs_cell_test.sv ----
`timescale 1ns/1ps
module lcs_cell_test
	import lcs_pkg::*;
();
	// ==========================================================
	// signals and model state
	logic              CORE_CLK, RST, CLK_EN, REG_WR, REG_RD;
	logic [ADDR_W-1:0] REG_ADDR;
	logic [DATA_W-1:0] REG_WDATA, REG_RDATA, rd_val;
	logic [3:0]        ctl, f_in, g_in, nxt_ctl, nxt_f, nxt_g, srcv;
	logic              global_preset_clear_net, nxt_gsr, f_out, g_out, h_out, o1, o2, q1, q2, fv, gv, hv;
	logic [15:0]       ftab, gtab;
	logic [7:0]        htab;
	int                err_count, compares, cyc, seed, wm, org;
	int                wm_t[5] = '{1, 1, 1, 0, 2};
	int                org_t[5] = '{0, 1, 2, 0, 2};
	// clock
	initial begin
		CORE_CLK = 1'h0;
		forever #4 CORE_CLK = ~CORE_CLK;
	end
	lcs_fabric u_fab (.clk(CORE_CLK), .nxt_ctl(nxt_ctl), .nxt_f(nxt_f), .nxt_g(nxt_g), .nxt_gsr(nxt_gsr),
		.ctl(ctl), .f_in(f_in), .g_in(g_in), .global_preset_clear_net(global_preset_clear_net));
	lcs_cell DUT (.CORE_CLK(CORE_CLK), .RST(RST), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
		.REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXTERNAL_CONTROL_INPUTS(ctl), .F_IN(f_in),
		.G_IN(g_in), .GLOBAL_PRESET_CLEAR_NET(global_preset_clear_net), .F_OUT(f_out), .G_OUT(g_out), .H_OUT(h_out),
		.REGISTERED_OUT_FIRST(o1), .REGISTERED_OUT_SECOND(o2));
	// ==========================================================
	// tasks
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chkb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		REG_WR <= 1'h1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CORE_CLK);
		REG_WR <= 1'h0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge CORE_CLK);
		REG_RD <= 1'h1;
		REG_ADDR <= a;
		@(posedge CORE_CLK);
		REG_RD <= 1'h0;
		@(negedge CORE_CLK);
		rd_val = REG_RDATA;
	endtask
	// inputs change at the one rising edge between the two negedges waited, so the model steps once
	task automatic fab(input logic [3:0] c, input logic [3:0] f, input logic [3:0] g, input logic s);
		@(negedge CORE_CLK);
		nxt_ctl = c;
		nxt_f = f;
		nxt_g = g;
		nxt_gsr = s;
		@(negedge CORE_CLK);
	endtask
	task automatic rnd();
		fab(4'($random(seed)), 4'($random(seed)), 4'($random(seed)), 1'h0);
	endtask
	// table write with write data on input 2, data one on input 3
	task automatic mwr();
		if (org == 0) begin
			ftab[f_in] = ctl[2];
			gtab[g_in] = ctl[3];
		end else if (org == 1) begin
			if (ctl[3]) gtab[f_in] = ctl[2];
			else ftab[f_in] = ctl[2];
		end else begin
			ftab[f_in] = ctl[2];
			if (wm == 2) gtab[f_in] = ctl[2];
		end
	endtask
	// a hang counts as a mismatch
	always @(posedge CORE_CLK) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			summarize();
		end
	end
	// ==========================================================
	// main sequence
	initial begin
		seed = 32'h048ab015;
		{RST, CLK_EN, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = {2'h3, 42'h0};
		{nxt_ctl, nxt_f, nxt_g, nxt_gsr} = 13'h0;
		repeat (8) @(posedge CORE_CLK);
		RST <= 1'h0;
		rd(OFF_STORE); chk("store", 32'(STORE_RST), rd_val);
		rd(OFF_MAP); chk("map", 32'(MAP_RST), rd_val);
		rd(8'h18); chk("unmapped", 32'h0, rd_val);
		$display("test reset done");
		// random tables, rotated control mapping, every data source
		ftab = 16'($random(seed));
		gtab = 16'($random(seed));
		htab = 8'($random(seed));
		wr(OFF_LUT_F, {16'h0, ftab});
		wr(OFF_LUT_G, {16'h0, gtab});
		wr(OFF_LUT_H, {24'h0, htab});
		rd(OFF_LUT_G); chk("gtab", {16'h0, gtab}, rd_val);
		for (int r = 0; r < 4; r++) begin
			fab(4'h0, 4'h0, 4'h0, 1'h0);
			wr(OFF_MAP, 32'(r | (((r + 1) % 4) << 2) | (((r + 2) % 4) << 4) | (((r + 3) % 4) << 6)));
			wr(OFF_STORE, 32'((r << 4) | ((3 - r) << 6)));
			{q1, q2} = 2'h0;
			for (int i = 0; i < 12; i++) begin
				rnd();
				fv = ftab[f_in];
				gv = gtab[g_in];
				hv = htab[{ctl[(r + 3) % 4], gv, fv}];
				srcv = {ctl[(r + 2) % 4], hv, gv, fv};
				chkb("q1", q1, o1);
				chkb("q2", q2, o2);
				chkb("h", hv, h_out);
				if (ctl[r]) {q1, q2} = {srcv[r], srcv[3 - r]};
			end
		end
		$display("test logic done");
		// global and local force, hold, bypass
		wr(OFF_MAP, 32'(MAP_RST));
		for (int v = 0; v < 4; v++) begin
			wr(OFF_STORE, 32'h000000F4 | v);
			fab(4'h0, 4'h0, 4'h0, 1'h1);
			chkb("gsr1", v[0], o1);
			chkb("gsr2", v[1], o2);
			// data reach the elements one fabric step after they are applied
			repeat (2) fab({1'h0, ~v[0], 2'h1}, 4'h0, 4'h0, 1'h0);
			chkb("load1", ~v[0], o1);
			fab({1'h0, v[0], 2'h2}, 4'h0, 4'h0, 1'h0);
			chkb("local1", v[0], o1);
			// gate low while direct data differ: second element must keep its value
			fab({1'h0, v[0], 2'h2}, 4'h0, 4'h0, 1'h0);
			chkb("hold2", ~v[0], o2);
			rd(OFF_STATUS);
			chk("status", 32'({htab[{1'h0, gtab[0], ftab[0]}], gtab[0], ftab[0], ~v[0], v[0]}), rd_val);
			wr(OFF_STORE, 32'(32'h300 | (v << 10) | ((3 - v) << 12)));
			rnd();
			chkb("byp1", ctl[v], o1);
			chkb("byp2", ctl[3 - v], o2);
		end
		$display("test force done");
		// memory modes and organisations
		for (int m = 0; m < 5; m++) begin
			wm = wm_t[m];
			org = org_t[m];
			fab(4'h0, 4'h0, 4'h0, 1'h0);
			wr(OFF_MAP, 32'(MAP_RST | (1 << 8) | (org << 9) | (wm << 11)));
			{ftab, gtab} = 32'h0;
			wr(OFF_LUT_F, 32'h0);
			wr(OFF_LUT_G, 32'h0);
			for (int i = 0; i < 16; i++) begin
				rnd();
				if (ctl[1] && wm == 0) mwr();
				chkb("fram", ftab[f_in], f_out);
				if (org == 1) chkb("hram", ctl[3] ? gtab[f_in] : ftab[f_in], h_out);
				else chkb("gram", gtab[g_in], g_out);
				if (ctl[1] && ctl[0] && wm != 0) mwr();
			end
			rd(OFF_LUT_G); chk("gtab", {16'h0, gtab}, rd_val);
		end
		$display("test memory done");
		// strobes ignored while frozen, then a second reset
		@(posedge CORE_CLK);
		CLK_EN <= 1'h0;
		wr(OFF_LUT_F, 32'h0000A5A5);
		CLK_EN <= 1'h1;
		rd(OFF_LUT_F); chk("frozen", {16'h0, ftab}, rd_val);
		@(posedge CORE_CLK);
		RST <= 1'h1;
		repeat (2) @(posedge CORE_CLK);
		RST <= 1'h0;
		rd(OFF_MAP); chk("map2", 32'(MAP_RST), rd_val);
		$display("test freeze done");
		summarize();
	end
endmodule
